/* hw/mopc_pkg.sv */
// constants for the modulator output, overrange and power control block
// assumes a 32-bit APB slave on core_clk and a sampled link clock pin
package mopc_pkg;

  // ***********************************************************
  // register indices and byte addresses (byte address = 4*index)
  // ***********************************************************
  localparam logic [11:0] IDX_CHAN_INDEX = 12'h005;
  localparam logic [11:0] IDX_PWR_MODE = 12'h008;
  localparam logic [11:0] IDX_DRV_STD = 12'h014;
  localparam logic [11:0] IDX_TERM = 12'h015;
  localparam logic [11:0] IDX_DCO_CTRL = 12'h016;
  localparam logic [11:0] IDX_OR_CTRL = 12'h111;
  localparam logic [11:0] ADDR_CHAN_INDEX = IDX_CHAN_INDEX << 2;
  localparam logic [11:0] ADDR_PWR_MODE = IDX_PWR_MODE << 2;
  localparam logic [11:0] ADDR_DRV_STD = IDX_DRV_STD << 2;
  localparam logic [11:0] ADDR_TERM = IDX_TERM << 2;
  localparam logic [11:0] ADDR_DCO_CTRL = IDX_DCO_CTRL << 2;
  localparam logic [11:0] ADDR_OR_CTRL = IDX_OR_CTRL << 2;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h600;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h604;
  localparam logic [11:0] ADDR_STATUS = 12'h608;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int PWR_B_LSB = 2;
  localparam int DRV_STD_BIT = 7;
  localparam int TERM_LSB = 4;
  localparam int DCO_INV_BIT = 7;
  localparam int OR_AUTO_MODULATOR_RESET_EN_BIT = 7;
  localparam int OR_SEL_A_BIT = 6;
  localparam int OR_SEL_B_BIT = 5;
  localparam int IRQ_OR_LSB = 0;
  localparam int IRQ_AR_LSB = 2;
  localparam int IRQ_W = 4;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [1:0] RST_CHAN_INDEX = 2'h3;
  localparam logic [1:0] RST_PWR_MODE = 2'h0;
  localparam logic RST_DRV_STD = 1'b0;
  localparam logic [1:0] RST_TERM = 2'h0;
  localparam logic RST_DCO_INV = 1'b0;
  localparam logic [2:0] RST_OR_CTRL = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

  // ***********************************************************
  // modes, states and counts
  // ***********************************************************
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_CHAN_DOWN = 2'h1,
    PWR_STANDBY = 2'h2,
    PWR_SLEEP = 2'h3
  } mopc_pwr_e;

  typedef enum logic [1:0] {
    AR_RUN = 2'b01,
    AR_RESET = 2'b10
  } mopc_ar_e;

  localparam int SAMPLE_W = 4;
  localparam int OR_RUN_LEN = 16;
  localparam int PIPE_LATENCY = 7;
  localparam int MOD_RESET_TICKS = 4;

endpackage

/* hw/mopc_tick_pipe.sv */
// enable-advanced delay line, one register per stage
// assumes adv is a one-cycle pulse on core_clk
`timescale 1ns/1ps
`default_nettype none
module mopc_tick_pipe #(
  parameter int W = 5,
  parameter int DEPTH = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic adv,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] stage;
  } mopc_pipe_s;

  mopc_pipe_s st;
  mopc_pipe_s next_st;

  always_comb begin
    next_st = st;
    if (adv) begin
      next_st.stage[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
        next_st.stage[i] = st.stage[i-1];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stage[DEPTH-1];

  a_pipe_shift: assert property (@(posedge core_clk) disable iff (rst)
    adv |=> dout == $past(st.stage[DEPTH-2]))
    else $error("pipe stage did not advance");
  a_pipe_hold: assert property (@(posedge core_clk) disable iff (rst)
    !adv |=> $stable(dout))
    else $error("pipe moved without advance");
endmodule
`default_nettype wire

/* hw/mopc_top.sv */
// modulator output, overrange and power control with APB registers
// assumes sample, over and busy inputs come from core_clk logic;
// link_clk_pin and the power-down pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - two-bit power code: normal, analog off, clock off too, reference off too
// - standby stops clocks and channels, keeps reference and drivers
// - sleep on both channels powers everything down and disables the output drivers
// - channel index picks channel A, B or both for power writes
// - outputs four-bit twos complement samples per channel, one per tick
// - one bit selects driver standard, full swing after reset
// - two-bit field selects output termination
// - overrange outputs update once per output data cycle
// - auto reset enable plus two mode selects choose overrange reporting
// - normal mode: indicator follows over-full-scale each cycle
// - data-valid mode: high unless out of range or memory busy
// - auto reset after 16 consecutive overrange cycles or saturation
// - during auto reset: normal mode high, data-valid mode low
// - seven-cycle pipeline from sampling to output
// - data clock rising edge marks data; a bit swaps the edge
module mopc_top
  import mopc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk_pin,
  input wire logic chan_a_powerdown_pin,
  input wire logic chan_b_powerdown_pin,
  input wire logic [SAMPLE_W-1:0] mod_a_sample,
  input wire logic [SAMPLE_W-1:0] mod_b_sample,
  input wire logic a_over_fullscale,
  input wire logic b_over_fullscale,
  input wire logic a_loop_saturated,
  input wire logic b_loop_saturated,
  input wire logic mem_access_busy,
  output logic [SAMPLE_W-1:0] data_a_out,
  output logic [SAMPLE_W-1:0] data_b_out,
  output logic overrange_a_out,
  output logic overrange_b_out,
  output logic data_clock_out,
  output logic out_driver_en,
  output logic [1:0] analog_on,
  output logic [1:0] clock_on,
  output logic reference_on,
  output logic [1:0] modulator_reset,
  output logic driver_standard_sel,
  output logic [1:0] output_termination_sel,
  output logic irq
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [2:0] lk;
    logic [1:0] pa;
    logic [1:0] pb;
    logic cfg_touched;
    logic [1:0] chan_index;
    logic [1:0][1:0] mode;
    logic drv_std;
    logic [1:0] term;
    logic dco_inv;
    logic auto_modulator_reset_en;
    logic sel_a;
    logic sel_b;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0][4:0] run;
    mopc_ar_e [1:0] ar;
    logic [1:0][2:0] rst_cnt;
    logic [1:0] over_prev;
    logic dco;
  } mopc_state_s;

  mopc_state_s st;
  mopc_state_s next_st;

  logic tick;
  logic wr;
  logic hit;
  logic dv_mode;
  logic [1:0] pin_pd;
  logic [1:0] over;
  logic [1:0] sat;
  logic [1:0] adv;
  logic [1:0] or_raw;
  logic [1:0][1:0] eff_mode;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // ***********************************************************
  // link clock edge and channel power
  // ***********************************************************
  // lk[0] feeds lk[1] only; the edge is taken between lk[1] and lk[2]
  assign tick = st.lk[1] & ~st.lk[2];
  assign over = {b_over_fullscale, a_over_fullscale};
  assign sat = {b_loop_saturated, a_loop_saturated};
  // pins only count while no register has ever been written
  assign pin_pd = {st.pb[1], st.pa[1]} & {2{~st.cfg_touched}};

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      eff_mode[c] = st.mode[c];
      if (pin_pd[c] && st.mode[c] == PWR_NORMAL) begin
        eff_mode[c] = PWR_CHAN_DOWN;
      end
      analog_on[c] = (eff_mode[c] == PWR_NORMAL);
      clock_on[c] = (eff_mode[c] == PWR_NORMAL) ||
                    (eff_mode[c] == PWR_CHAN_DOWN);
    end
  end

  assign reference_on = (eff_mode[0] != PWR_SLEEP) ||
                        (eff_mode[1] != PWR_SLEEP);
  // drivers stay up in standby so the link is kept
  assign out_driver_en = reference_on;
  assign adv = clock_on & {2{tick}};

  // ***********************************************************
  // overrange reporting
  // ***********************************************************
  assign dv_mode = st.sel_a & st.sel_b;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      modulator_reset[c] = (st.ar[c] == AR_RESET);
      if (dv_mode) begin
        or_raw[c] = ~(mem_access_busy | modulator_reset[c] |
                      over[c]);
      end else begin
        or_raw[c] = over[c] | modulator_reset[c];
      end
    end
  end

  // ***********************************************************
  // register bus
  // ***********************************************************
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == ADDR_CHAN_INDEX) || (paddr == ADDR_PWR_MODE) ||
               (paddr == ADDR_DRV_STD) || (paddr == ADDR_TERM) ||
               (paddr == ADDR_DCO_CTRL) || (paddr == ADDR_OR_CTRL) ||
               (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK) ||
               (paddr == ADDR_STATUS);
  assign pslverr = psel & penable & ~hit;
  assign irq_clr = (wr && paddr == ADDR_IRQ_STATUS) ?
                   pwdata[IRQ_W-1:0] : '0;

  always_comb begin
    prdata = '0;
    unique case (paddr)
      ADDR_CHAN_INDEX: prdata[1:0] = st.chan_index;
      ADDR_PWR_MODE: prdata[3:0] = {st.mode[1], st.mode[0]};
      ADDR_DRV_STD: prdata[DRV_STD_BIT] = st.drv_std;
      ADDR_TERM: prdata[TERM_LSB+:2] = st.term;
      ADDR_DCO_CTRL: prdata[DCO_INV_BIT] = st.dco_inv;
      ADDR_OR_CTRL: prdata[OR_SEL_B_BIT+:3] =
        {st.auto_modulator_reset_en, st.sel_a, st.sel_b};
      ADDR_IRQ_STATUS: prdata[IRQ_W-1:0] = st.irq_status;
      ADDR_IRQ_MASK: prdata[IRQ_W-1:0] = st.irq_mask;
      ADDR_STATUS: prdata[5:0] = {modulator_reset, eff_mode[1],
                                  eff_mode[0]};
      default: prdata = '0;
    endcase
  end

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    next_st = st;
    irq_set = '0;
    next_st.lk = {st.lk[1:0], link_clk_pin};
    next_st.pa = {st.pa[0], chan_a_powerdown_pin};
    next_st.pb = {st.pb[0], chan_b_powerdown_pin};
    if (wr) begin
      next_st.cfg_touched = 1'b1;
      unique case (paddr)
        ADDR_CHAN_INDEX: next_st.chan_index = pwdata[1:0];
        ADDR_PWR_MODE: begin
          for (int c = 0; c < 2; c++) begin
            if (st.chan_index[c]) begin
              next_st.mode[c] = pwdata[1:0];
            end
          end
        end
        ADDR_DRV_STD: next_st.drv_std = pwdata[DRV_STD_BIT];
        ADDR_TERM: next_st.term = pwdata[TERM_LSB+:2];
        ADDR_DCO_CTRL: next_st.dco_inv = pwdata[DCO_INV_BIT];
        ADDR_OR_CTRL: begin
          next_st.auto_modulator_reset_en = pwdata[OR_AUTO_MODULATOR_RESET_EN_BIT];
          next_st.sel_a = pwdata[OR_SEL_A_BIT];
          next_st.sel_b = pwdata[OR_SEL_B_BIT];
        end
        ADDR_IRQ_MASK: next_st.irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      if (adv[c]) begin
        next_st.over_prev[c] = over[c];
        if (over[c] && !st.over_prev[c]) begin
          irq_set[IRQ_OR_LSB+c] = 1'b1;
        end
        unique case (st.ar[c])
          AR_RUN: begin
            // a pwm-like indicator is not yet an overload: wait for a run
            if (st.auto_modulator_reset_en && ((over[c] &&
                st.run[c] == 5'(OR_RUN_LEN - 1)) || sat[c])) begin
              next_st.ar[c] = AR_RESET;
              next_st.rst_cnt[c] = '0;
              next_st.run[c] = '0;
              irq_set[IRQ_AR_LSB+c] = 1'b1;
            end else if (over[c]) begin
              if (st.run[c] != 5'(OR_RUN_LEN - 1)) begin
                next_st.run[c] = st.run[c] + 5'h01;
              end
            end else begin
              next_st.run[c] = '0;
            end
          end
          AR_RESET: begin
            if (st.rst_cnt[c] == 3'(MOD_RESET_TICKS - 1)) begin
              next_st.ar[c] = AR_RUN;
            end else begin
              next_st.rst_cnt[c] = st.rst_cnt[c] + 3'h1;
            end
          end
          default: next_st.ar[c] = AR_RUN;
        endcase
      end
    end
    // a new event wins over a clear in the same cycle
    next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
    // data changes on the link rising edge; the clock out rises mid-cycle
    if (clock_on != 2'b00) begin
      next_st.dco = st.lk[1] ^ ~st.dco_inv;
    end else begin
      next_st.dco = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.chan_index <= RST_CHAN_INDEX;
      st.mode <= {RST_PWR_MODE, RST_PWR_MODE};
      st.drv_std <= RST_DRV_STD;
      st.term <= RST_TERM;
      st.dco_inv <= RST_DCO_INV;
      {st.auto_modulator_reset_en, st.sel_a, st.sel_b} <= RST_OR_CTRL;
      st.irq_mask <= RST_IRQ_MASK;
      st.ar[0] <= AR_RUN;
      st.ar[1] <= AR_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ***********************************************************
  // output pipelines
  // ***********************************************************
  // overrange travels with its sample so both leave in the same cycle
  mopc_tick_pipe #(.W(SAMPLE_W + 1), .DEPTH(PIPE_LATENCY)) u_pipe_a (
    .core_clk(core_clk),
    .rst(rst),
    .adv(adv[0]),
    .din({or_raw[0], mod_a_sample}),
    .dout({overrange_a_out, data_a_out})
  );

  mopc_tick_pipe #(.W(SAMPLE_W + 1), .DEPTH(PIPE_LATENCY)) u_pipe_b (
    .core_clk(core_clk),
    .rst(rst),
    .adv(adv[1]),
    .din({or_raw[1], mod_b_sample}),
    .dout({overrange_b_out, data_b_out})
  );

  assign data_clock_out = st.dco;
  assign driver_standard_sel = st.drv_std;
  assign output_termination_sel = st.term;
  assign irq = |(st.irq_status & st.irq_mask);

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_standby_keeps_ref: assert property (
    wr && paddr == ADDR_PWR_MODE && st.chan_index == 2'h3 &&
    pwdata[1:0] == 2'h2 |=> clock_on == 2'b00 && reference_on &&
    out_driver_en)
    else $error("standby did not keep reference and drivers");
  a_sleep_drivers_off: assert property (
    wr && paddr == ADDR_PWR_MODE && st.chan_index == 2'h3 &&
    pwdata[1:0] == 2'h3 |=> !out_driver_en && !reference_on)
    else $error("sleep left drivers on");
  a_index_spares_b: assert property (
    wr && paddr == ADDR_PWR_MODE && st.chan_index == 2'h1 |=>
    $stable(st.mode[1]))
    else $error("channel index 1 touched channel b");
  a_pin_power_down: assert property (
    !st.cfg_touched && st.pa[1] |-> !analog_on[0])
    else $error("power-down pin ignored");
  a_driver_std_write: assert property (
    wr && paddr == ADDR_DRV_STD |=>
    driver_standard_sel == $past(pwdata[DRV_STD_BIT]))
    else $error("driver standard not taken");
  a_term_write: assert property (
    wr && paddr == ADDR_TERM |=>
    output_termination_sel == $past(pwdata[TERM_LSB+:2]))
    else $error("termination not taken");
  a_or_only_on_tick: assert property (
    !$stable(overrange_a_out) |-> $past(adv[0]))
    else $error("overrange changed between output cycles");
  a_auto_reset_start: assert property (
    adv[1] && st.ar[1] == AR_RUN && st.auto_modulator_reset_en && sat[1] |=>
    modulator_reset[1])
    else $error("saturation did not start modulator reset");
  a_no_reset_early: assert property (
    adv[0] && st.ar[0] == AR_RUN && !sat[0] &&
    st.run[0] < 5'(OR_RUN_LEN - 1) |=> !modulator_reset[0])
    else $error("modulator reset before 16 cycles");
  a_reset_indicator: assert property (
    modulator_reset[0] |-> or_raw[0] == !dv_mode)
    else $error("indicator wrong during modulator reset");
  a_dv_busy_low: assert property (
    dv_mode && mem_access_busy |-> !or_raw[1])
    else $error("data-valid indicator high during memory access");
  a_mixed_is_normal: assert property (
    st.sel_a != st.sel_b && !modulator_reset[0] |->
    or_raw[0] == over[0])
    else $error("mixed selects not treated as normal");
  a_irq_set_wins: assert property (
    irq_set[0] |=> st.irq_status[0])
    else $error("event lost against clear");

  c_auto_reset: cover property (adv[0] && modulator_reset[0]);
  c_standby: cover property (clock_on == 2'b00 && reference_on);
  c_dv_mode: cover property (dv_mode && adv[1] && or_raw[1]);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

/* testbench/mopc_rx_model.sv */
// receiver model: captures both channels against the data clock
// assumes the data clock's rising edge marks valid data (inversion clear)
`timescale 1ns/1ps
`default_nettype none
module mopc_rx_model
  import mopc_pkg::*;
(
  input wire logic data_clock,
  input wire logic [SAMPLE_W-1:0] data_a,
  input wire logic [SAMPLE_W-1:0] data_b,
  input wire logic ind_a,
  input wire logic ind_b,
  output logic [SAMPLE_W-1:0] cap_a,
  output logic [SAMPLE_W-1:0] cap_b,
  output logic [1:0] cap_ind,
  output logic [15:0] cap_cnt
);
  // ******************************************
  // capture
  // ******************************************
  initial cap_cnt = 16'h0;
  always @(posedge data_clock) begin
    cap_a <= data_a;
    cap_b <= data_b;
    cap_cnt <= cap_cnt + 16'h1;
  end
  // flags taken on the falling edge, which lands at the start of the data cycle
  always @(negedge data_clock)
    cap_ind <= {ind_b, ind_a};
endmodule
`default_nettype wire

/* testbench/test_mopc_top.sv */
// self-checking bench for the modulator output and power control block
// assumes the package, the design and the receiver model compile first
`timescale 1ns/1ps
`default_nettype none
module test_mopc_top
  import mopc_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, q, rnd_word;
  logic pready, pslverr, e;
  logic link_clk_pin = 1'b0;
  logic chan_a_powerdown_pin = 1'b0, chan_b_powerdown_pin = 1'b0;
  logic [SAMPLE_W-1:0] mod_a_sample = '0, mod_b_sample = '0;
  logic a_over_fullscale = 1'b0, b_over_fullscale = 1'b0;
  logic a_loop_saturated = 1'b0, b_loop_saturated = 1'b0;
  logic mem_access_busy = 1'b0;
  logic [SAMPLE_W-1:0] data_a_out, data_b_out, rx_a, rx_b;
  logic overrange_a_out, overrange_b_out, data_clock_out, out_driver_en;
  logic [1:0] analog_on, clock_on, modulator_reset, output_termination_sel;
  logic [1:0] rx_ind, pm_a = 2'h0, pm_b = 2'h0;
  logic reference_on, driver_standard_sel, irq;
  logic [15:0] rx_cnt;
  logic [10:0] hist [$];
  logic rnd_on = 1'b0, chk_on = 1'b0;
  logic [2:0] ovr_mode = 3'h0;
  logic [2:0] modes [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
  int seed = 95, error_cnt = 0, checks_done = 0, cyc = 0, skip = 0;
  int zeros, k;
  localparam int LIMIT = 10000;

  always #10 core_clk = ~core_clk;
  // link phase offset keeps its edges off the core edges
  initial begin
    #7;
    forever #80 link_clk_pin = ~link_clk_pin;
  end

  mopc_top i_mopc_top (
    .core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .link_clk_pin, .chan_a_powerdown_pin,
    .chan_b_powerdown_pin, .mod_a_sample, .mod_b_sample, .a_over_fullscale,
    .b_over_fullscale, .a_loop_saturated, .b_loop_saturated,
    .mem_access_busy, .data_a_out, .data_b_out, .overrange_a_out,
    .overrange_b_out, .data_clock_out, .out_driver_en, .analog_on,
    .clock_on, .reference_on, .modulator_reset, .driver_standard_sel,
    .output_termination_sel, .irq
  );
  mopc_rx_model i_mopc_rx_model (
    .data_clock(data_clock_out), .data_a(data_a_out), .data_b(data_b_out),
    .ind_a(overrange_a_out), .ind_b(overrange_b_out),
    .cap_a(rx_a), .cap_b(rx_b), .cap_ind(rx_ind), .cap_cnt(rx_cnt)
  );

  // ******************************************
  // tasks and expectations
  // ******************************************
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // the wait ends once pready is high; only the bench timeout ends a stuck wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    cmp(pready, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask

  // n link rising edges, then past the synchronizer and the tick's update
  task automatic ticks(input int n);
    repeat (n) @(posedge link_clk_pin);
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  task automatic pwr(input logic [1:0] idx, input logic [1:0] code);
    if (idx[0]) pm_a = code;
    if (idx[1]) pm_b = code;
    wr(ADDR_CHAN_INDEX, {30'h0, idx});
    wr(ADDR_PWR_MODE, {30'h0, code});
    rd(ADDR_PWR_MODE, {28'h0, pm_b, pm_a});
    #1;
    cmp(analog_on, {pm_b == 2'h0, pm_a == 2'h0});
    cmp(clock_on, {pm_b < 2'h2, pm_a < 2'h2});
    cmp(out_driver_en, !(pm_a == 2'h3 && pm_b == 2'h3));
    if (pm_a == pm_b)
      cmp(reference_on, pm_a != 2'h3);
  endtask

  function automatic logic [1:0] ind_exp(input logic [10:0] h);
    if (ovr_mode[1:0] == 2'b11)
      return ~({2{h[10]}} | h[9:8]);
    return h[9:8];
  endfunction

  // ******************************************
  // stream stimulus and checking
  // ******************************************
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      end_sim();
    end
  end

  always @(negedge link_clk_pin) if (rnd_on) begin
    @(posedge core_clk);
    rnd_word = $random(seed);
    mod_a_sample <= rnd_word[3:0];
    mod_b_sample <= rnd_word[7:4];
    if (rnd_word[10:8] == 3'h0) a_over_fullscale <= ~a_over_fullscale;
    if (rnd_word[13:11] == 3'h0) b_over_fullscale <= ~b_over_fullscale;
    if (rnd_word[16:14] == 3'h0) mem_access_busy <= ~mem_access_busy;
  end

  always @(posedge link_clk_pin)
    hist.push_back({mem_access_busy, b_over_fullscale, a_over_fullscale,
                    mod_b_sample, mod_a_sample});

  // flags are compared only where they stand across two ticks
  always @(rx_cnt) if (chk_on) begin
    k = hist.size() - PIPE_LATENCY;
    if (skip > 0)
      skip--;
    else if (k > 2) begin
      cmp({rx_b, rx_a}, hist[k][7:0]);
      if (ind_exp(hist[k]) == ind_exp(hist[k-1]))
        cmp(rx_ind, ind_exp(hist[k]));
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_CHAN_INDEX, 32'h3);
    rd(ADDR_PWR_MODE, 32'h0);
    rd(ADDR_DRV_STD, 32'h0);
    rd(ADDR_TERM, 32'h0);
    rd(ADDR_DCO_CTRL, 32'h0);
    rd(ADDR_OR_CTRL, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    cmp(driver_standard_sel, 1'b0);
    // pins rule the channels only while no register write has happened
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      {chan_b_powerdown_pin, chan_a_powerdown_pin} <= 2'h1 << i;
      repeat (4) @(posedge core_clk);
      #1;
      cmp(analog_on, 2'(2'h3 ^ (2'h1 << i)));
      cmp(clock_on, 2'h3);
    end
    rnd_on = 1'b1;
    chk_on = 1'b1;
    foreach (modes[i]) begin
      ovr_mode = modes[i];
      skip = 9;
      wr(ADDR_OR_CTRL, {24'h0, modes[i], 5'h0});
      ticks(40);
    end
    chk_on = 1'b0;
    wr(ADDR_DRV_STD, 32'h80);
    rd(ADDR_DRV_STD, 32'h80);
    cmp(driver_standard_sel, 1'b1);
    for (int t = 1; t < 4; t++) begin
      wr(ADDR_TERM, t << TERM_LSB);
      rd(ADDR_TERM, t << TERM_LSB);
      cmp(output_termination_sel, t);
    end
    apb(1'b1, 12'h7FC, 32'hFFFF_FFFF);
    cmp(e, 1'b1);
    apb(1'b0, 12'h7FC, 32'h0);
    cmp(e, 1'b1);
    cmp(q, 32'h0);
    for (int v = 1; v >= 0; v--) begin
      wr(ADDR_DCO_CTRL, v << DCO_INV_BIT);
      ticks(1);
      cmp(data_clock_out, v);
    end
    for (int c = 0; c < 4; c++)
      pwr(2'h3, c[1:0]);
    pwr(2'h1, 2'h0);
    pwr(2'h2, 2'h2);
    pwr(2'h0, 2'h1);
    pwr(2'h3, 2'h0);
    @(posedge core_clk);
    chan_a_powerdown_pin <= 1'b1;
    ticks(1);
    cmp(analog_on, 2'h3);
    @(posedge core_clk);
    chan_a_powerdown_pin <= 1'b0;
    rnd_on = 1'b0;
    ovr_mode = 3'h4;
    wr(ADDR_OR_CTRL, 32'h80);
    @(posedge core_clk);
    a_over_fullscale <= 1'b0;
    b_over_fullscale <= 1'b0;
    mem_access_busy <= 1'b0;
    ticks(2);
    @(negedge link_clk_pin);
    @(posedge core_clk);
    a_over_fullscale <= 1'b1;
    ticks(15);
    cmp(modulator_reset, 2'h0);
    ticks(1);
    cmp(modulator_reset, 2'h1);
    @(posedge core_clk);
    a_over_fullscale <= 1'b0;
    ovr_mode = 3'h7;
    wr(ADDR_OR_CTRL, 32'hE0);
    ticks(9);
    @(negedge link_clk_pin);
    @(posedge core_clk);
    b_loop_saturated <= 1'b1;
    ticks(1);
    cmp(modulator_reset[1], 1'b1);
    @(posedge core_clk);
    b_loop_saturated <= 1'b0;
    zeros = 0;
    repeat (14) begin
      ticks(1);
      zeros += !overrange_b_out;
    end
    cmp(zeros, MOD_RESET_TICKS);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    cmp(q[3:0] & 4'hD, 4'hD);
    // a set mask bit lets its status bit through to irq
    wr(ADDR_IRQ_MASK, 32'h0);
    #1;
    cmp(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'hF);
    #1;
    cmp(irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 32'hF);
    rd(ADDR_IRQ_STATUS, 32'h0);
    cmp(irq, 1'b0);
    rd(ADDR_STATUS, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
